// *** core/cbc_cfg.svh ***
// constants for the count-register conditional branch unit
// assumes big-endian bit numbering of the 32-bit instruction word (bit 0 = msb)
// Functional notes
// [RQ1] recognise primary opcode 19, extended opcode 528; bit 31 is link enable
// [RQ2] taken target is count register bits 0-29 with two zero low bits
// [RQ3] link enable set writes next instruction address to link register
// [RQ4] never modify fixed-point exception register or condition field 0
// [RQ5] codes 0000y/0001y/0100y/0101y decrement, test counter and condition bit
// [RQ6] 001zy branch on false, 011zy on true, 1z1zz always; counter untouched
// [RQ7] codes 1z00y/1z01y decrement and test counter only
// [RQ8] newer architecture: nonzero z position is an invalid form
// [RQ9] legacy y bit is only a likelihood hint, default zero
// [RQ10] legacy variant accepts any z and y values
// [RQ11] newer encoding carries a,t hints in marked positions, z lowest otherwise
// [RQ12] a,t hint: 00 none, 01 reserved, 10 not taken, 11 taken
// [RQ13] usage hint: 00 repeat target, 11 unpredictable, 01 and 10 reserved
// [RQ14] condition select picks one condition register bit to test
// [RQ15] decrementing codes are invalid forms for this instruction
`ifndef CBC_CFG_SVH
`define CBC_CFG_SVH
`define CBC_PRIMARY_OP 6'h13
`define CBC_EXTENDED_OP 10'h210
`define CBC_ZERO_LOW 2'h0
`define CBC_AT_NONE 2'h0
`define CBC_AT_RSVD 2'h1
`define CBC_AT_NOT_TAKEN 2'h2
`define CBC_AT_TAKEN 2'h3
`define CBC_BH_REPEAT 2'h0
`define CBC_BH_UNPRED 2'h3
`define CBC_NEXT_STEP 32'h4
`define CBC_CR_TOP 5'h1f
`define CBC_BO_ALWAYS 5'h14
`define CBC_BO_ALWAYS_Z 5'h15
`endif

// *** core/cbc_pkg.sv ***
// types for the count-register conditional branch unit
// assumes nothing beyond the shared constant header
package cbc_pkg;
    typedef enum logic [1:0] {
        CBC_HINT_NONE = 2'h0,
        CBC_HINT_RSVD = 2'h1,
        CBC_HINT_NOT_TAKEN = 2'h2,
        CBC_HINT_TAKEN = 2'h3
    } cbc_hint_type;

    typedef enum logic [1:0] {
        CBC_USE_REPEAT = 2'h0,
        CBC_USE_RSVD = 2'h1,
        CBC_USE_RSVD2 = 2'h2,
        CBC_USE_UNPRED = 2'h3
    } cbc_use_type;

    typedef struct packed {
        logic [5:0] primary_op;
        logic [4:0] branch_option_field;
        logic [4:0] condition_bit_select;
        logic [2:0] unused;
        logic [1:0] branch_usage_hint;
        logic [9:0] extended_op;
        logic link_enable_bit;
    } cbc_insn_type;

    typedef struct packed {
        logic valid;
        logic taken;
        logic invalid_form;
        logic link_write;
        logic [31:0] target;
        logic [31:0] link_value;
        cbc_hint_type take_hint;
        cbc_use_type usage_hint;
    } cbc_result_type;
endpackage

// *** core/cbc_unit.sv ***
// decode and execute of the conditional branch to the count register
// assumes instruction, address and register values arrive on CLK_I from the core
`timescale 1ns/1ps
`default_nettype none
`include "cbc_cfg.svh"
module cbc_unit
    import cbc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic ISSUE_I,
    input wire logic [31:0] INSN_I,
    input wire logic [31:0] INSN_ADDR_I,
    input wire logic [31:0] LOOP_COUNT_I,
    input wire logic [31:0] COND_REG_I,
    input wire logic LEGACY_MODE_I,
    output logic RESULT_VALID_O,
    output logic TAKEN_O,
    output logic INVALID_FORM_O,
    output logic [31:0] NEXT_FETCH_O,
    output logic LINK_WE_O,
    output logic [31:0] LINK_DATA_O,
    output logic [1:0] TAKE_HINT_O,
    output logic [1:0] USAGE_HINT_O
);
    // bit index in big-endian numbering to the little-endian vector position
    function automatic logic pick_cond(input logic [31:0] cr, input logic [4:0] sel);
        pick_cond = cr[`CBC_CR_TOP - sel];
    endfunction

    cbc_insn_type insn;
    logic [4:0] bo;
    logic match;
    logic wants_dec;
    logic cond_ok;
    logic z_bad;
    logic invalid;
    logic taken;
    cbc_hint_type hint;
    cbc_result_type next_res;
    cbc_result_type res;

    assign insn = INSN_I;
    assign bo = insn.branch_option_field;
    assign match = ISSUE_I && insn.primary_op == `CBC_PRIMARY_OP
        && insn.extended_op == `CBC_EXTENDED_OP; // RQ1
    // counter decrement requested when bo bit 2 (big-endian) is zero
    assign wants_dec = ~bo[2]; // RQ5 RQ7
    // condition ignored when bo bit 0 set; else compare selected bit with bo bit 1
    assign cond_ok = bo[4] | (pick_cond(COND_REG_I, insn.condition_bit_select) == bo[3]); // RQ14 RQ6
    // z positions per newer encoding: 1z1zz -> bits 1,3,4; counter-and-condition codes -> lowest bit; counter-only codes none
    assign z_bad = bo[4] ? (bo[2] ? (bo[3] | bo[1] | bo[0]) : 1'b0)
                         : (bo[2] ? 1'b0 : bo[0]); // RQ8 RQ11
    // target is the counter itself, so decrementing forms cannot execute
    assign invalid = wants_dec | (~LEGACY_MODE_I & z_bad); // RQ15 RQ10
    assign taken = ~invalid & cond_ok; // RQ6 RQ9 RQ12
    // a,t live in bits 3,4 for 001at/011at; legacy y is a hint only
    assign hint = LEGACY_MODE_I ? (bo[0] ? CBC_HINT_TAKEN : CBC_HINT_NONE)
                : (bo[4] ? CBC_HINT_NONE : cbc_hint_type'(bo[1:0])); // RQ9 RQ11 RQ12

    always_comb begin
        next_res.valid = match;
        next_res.taken = match & taken;
        next_res.invalid_form = match & invalid;
        next_res.link_write = match & ~invalid & insn.link_enable_bit; // RQ3
        next_res.target = (match & taken) ? {LOOP_COUNT_I[31:2], `CBC_ZERO_LOW}
                        : INSN_ADDR_I + `CBC_NEXT_STEP; // RQ2
        next_res.link_value = INSN_ADDR_I + `CBC_NEXT_STEP; // RQ3
        next_res.take_hint = hint;
        next_res.usage_hint = cbc_use_type'(insn.branch_usage_hint); // RQ13
    end

    // no exception or condition register outputs exist: both stay untouched
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            res <= '0;
        end else if (CE_I) begin
            res <= next_res; // RQ4
        end
    end

    assign RESULT_VALID_O = res.valid;
    assign TAKEN_O = res.taken;
    assign INVALID_FORM_O = res.invalid_form;
    assign NEXT_FETCH_O = res.target;
    assign LINK_WE_O = res.link_write;
    assign LINK_DATA_O = res.link_value;
    assign TAKE_HINT_O = res.take_hint;
    assign USAGE_HINT_O = res.usage_hint;

    // checkers below watch registered outputs one enabled edge after the decode
    logic sel_bit;
    assign sel_bit = pick_cond(COND_REG_I, insn.condition_bit_select); // RQ14

    sequence s_accept;
        CE_I && match;
    endsequence

    sequence s_exec;
        CE_I && match && !invalid;
    endsequence

    sequence s_idle;
        CE_I && !match;
    endsequence

    sequence s_hold;
        !CE_I;
    endsequence

    sequence s_always_legal;
        CE_I && match && !LEGACY_MODE_I && bo == `CBC_BO_ALWAYS;
    endsequence

    sequence s_new_cond;
        CE_I && match && !LEGACY_MODE_I && !bo[4] && bo[2];
    endsequence

    a_target_low_zero: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ2
        TAKEN_O |-> NEXT_FETCH_O[1:0] == `CBC_ZERO_LOW)
        else $error("target low bits");

    a_target_from_count: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ2
        CE_I && match && taken |=> NEXT_FETCH_O[31:2] == $past(LOOP_COUNT_I[31:2]))
        else $error("target not from counter");

    a_link_follows_bit: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ3
        s_exec |=> LINK_WE_O == $past(insn.link_enable_bit))
        else $error("link write mismatch");

    a_link_next_addr: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ3
        LINK_WE_O && !TAKEN_O |-> LINK_DATA_O == NEXT_FETCH_O)
        else $error("link data wrong");

    a_decode_match: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ1
        CE_I && ISSUE_I && INSN_I[31:26] != `CBC_PRIMARY_OP |=> !RESULT_VALID_O)
        else $error("wrong opcode accepted");

    a_dec_invalid: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ15
        CE_I && match && !bo[2] |=> INVALID_FORM_O && !TAKEN_O)
        else $error("decrement form executed");

    a_always_taken: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ6
        s_always_legal |=> TAKEN_O)
        else $error("always not taken");

    a_z_nonzero_bad: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ8
        CE_I && match && !LEGACY_MODE_I && bo == `CBC_BO_ALWAYS_Z |=> INVALID_FORM_O)
        else $error("z not checked");

    a_legacy_z_ok: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ10
        CE_I && match && LEGACY_MODE_I && bo[4] && bo[2] |=> TAKEN_O)
        else $error("legacy z flagged");

    a_cond_test: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ14
        CE_I && match && bo[2] && !bo[4] && !z_bad |=>
        TAKEN_O == ($past(sel_bit) == $past(bo[3])))
        else $error("condition test wrong");

    a_ext_op_match: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ1
        CE_I && ISSUE_I && INSN_I[10:1] != `CBC_EXTENDED_OP |=> !RESULT_VALID_O)
        else $error("wrong extended opcode accepted");

    a_no_issue_idle: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ1
        CE_I && !ISSUE_I |=> !RESULT_VALID_O)
        else $error("result without issue");

    a_valid_on_match: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ1
        s_accept |=> RESULT_VALID_O)
        else $error("matching word dropped");

    a_back_to_back: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ1
        s_exec ##1 s_exec |=> RESULT_VALID_O)
        else $error("second issue lost");

    a_taken_needs_valid: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ1
        TAKEN_O |-> RESULT_VALID_O)
        else $error("taken without result");

    a_invalid_needs_valid: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ8
        INVALID_FORM_O |-> RESULT_VALID_O)
        else $error("invalid flag without result");

    a_link_needs_valid: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ3
        LINK_WE_O |-> RESULT_VALID_O && !INVALID_FORM_O)
        else $error("link write without legal result");

    a_link_off_clear: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ3
        s_exec && !insn.link_enable_bit |=> !LINK_WE_O)
        else $error("link written with bit clear");

    a_link_data_next: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ3
        s_accept |=> LINK_DATA_O == $past(INSN_ADDR_I) + `CBC_NEXT_STEP)
        else $error("link data not next address");

    a_not_taken_seq: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ2
        CE_I && match && !taken |=> NEXT_FETCH_O == $past(INSN_ADDR_I) + `CBC_NEXT_STEP)
        else $error("fall-through address wrong");

    a_always_target: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ2
        s_always_legal |=> NEXT_FETCH_O == {$past(LOOP_COUNT_I[31:2]), `CBC_ZERO_LOW})
        else $error("always target wrong");

    a_invalid_no_taken: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ15
        INVALID_FORM_O |-> !TAKEN_O)
        else $error("invalid form taken");

    a_invalid_no_link: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ15
        INVALID_FORM_O |-> !LINK_WE_O)
        else $error("invalid form wrote link");

    a_dec_noncond: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ7
        CE_I && match && bo[4] && !bo[2] |=> INVALID_FORM_O)
        else $error("counter-only form executed");

    a_dec_cond: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ5
        CE_I && match && !bo[4] && !bo[2] |=> INVALID_FORM_O)
        else $error("counter-and-condition form executed");

    a_false_branch: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ6
        CE_I && match && !bo[4] && !bo[3] && bo[2] |=> TAKEN_O == !$past(sel_bit))
        else $error("branch on false wrong");

    a_true_branch: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ6
        CE_I && match && !bo[4] && bo[3] && bo[2] |=> TAKEN_O == $past(sel_bit))
        else $error("branch on true wrong");

    a_legacy_any_z: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ10
        CE_I && match && LEGACY_MODE_I && bo[2] |=> !INVALID_FORM_O)
        else $error("legacy form flagged");

    a_new_z_always: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ8
        CE_I && match && !LEGACY_MODE_I && bo[4] && bo[2] && (bo[3] || bo[1] || bo[0])
        |=> INVALID_FORM_O)
        else $error("nonzero z accepted");

    a_new_at_ok: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ11
        s_new_cond |=> !INVALID_FORM_O)
        else $error("hint bits flagged as z");

    a_hint_at_pass: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ12
        s_new_cond |=> TAKE_HINT_O == $past(bo[1:0]))
        else $error("a,t hint not passed");

    a_always_hint_none: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ11
        s_always_legal |=> TAKE_HINT_O == `CBC_AT_NONE)
        else $error("always form reports hint");

    a_hint_legacy: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ9
        CE_I && match && LEGACY_MODE_I && !bo[0] |=> TAKE_HINT_O == `CBC_AT_NONE)
        else $error("legacy default hint wrong");

    a_hint_legacy_y: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ9
        CE_I && match && LEGACY_MODE_I && bo[0] |=> TAKE_HINT_O == `CBC_AT_TAKEN)
        else $error("legacy y hint wrong");

    a_hint_no_rsvd: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ12
        CE_I && match && LEGACY_MODE_I |=> TAKE_HINT_O != `CBC_AT_RSVD)
        else $error("legacy reports reserved hint");

    a_usage_pass: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ13
        s_accept |=> USAGE_HINT_O == $past(insn.branch_usage_hint))
        else $error("usage hint not passed");

    a_idle_quiet: assert property (@(posedge CLK_I) disable iff (RST_I) // RQ3
        s_idle |=> !LINK_WE_O && !TAKEN_O && !INVALID_FORM_O)
        else $error("flags raised without match");

    // clock enable low must freeze every registered output
    a_freeze_valid: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_hold |=> $stable(RESULT_VALID_O))
        else $error("valid moved while frozen");

    a_freeze_fetch: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_hold |=> $stable(NEXT_FETCH_O))
        else $error("fetch moved while frozen");

    a_freeze_link: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_hold |=> $stable(LINK_WE_O) && $stable(LINK_DATA_O))
        else $error("link moved while frozen");

    a_freeze_flags: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_hold |=> $stable(TAKEN_O) && $stable(INVALID_FORM_O))
        else $error("flags moved while frozen");

    a_freeze_hints: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_hold |=> $stable(TAKE_HINT_O) && $stable(USAGE_HINT_O))
        else $error("hints moved while frozen");

    // reset wins over clock enable, so these carry no disable clause
    a_reset_clear: assert property (@(posedge CLK_I)
        RST_I |=> !RESULT_VALID_O && !TAKEN_O && !LINK_WE_O && !INVALID_FORM_O)
        else $error("flags not cleared by reset");

    a_reset_data: assert property (@(posedge CLK_I)
        RST_I |=> NEXT_FETCH_O == '0 && LINK_DATA_O == '0)
        else $error("data not cleared by reset");

    a_reset_hints: assert property (@(posedge CLK_I)
        RST_I |=> TAKE_HINT_O == `CBC_AT_NONE && USAGE_HINT_O == `CBC_BH_REPEAT)
        else $error("hints not cleared by reset");
endmodule
`default_nettype wire

// *** testbench/cbc_unit_test.sv ***
// self-checking bench for the count-register conditional branch unit
// assumes cbc_pkg is compiled first and results register one enabled edge after issue
`timescale 1ns/1ps
`default_nettype none
module cbc_unit_test
    import cbc_pkg::*;
;
    logic clk = 1'b0;
    logic rst, ce, issue, legacy, vld, tkn, inv, lwe, hok;
    logic [31:0] insn, addr, ctr, cr, nf, ld;
    logic [1:0] th, uh;
    logic [31:0] seed = 32'hcc05f233;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    cbc_result_type ex;

    always #12.5 clk = ~clk;

    cbc_unit cbc_unit_inst (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .ISSUE_I(issue),
        .INSN_I(insn), .INSN_ADDR_I(addr), .LOOP_COUNT_I(ctr), .COND_REG_I(cr),
        .LEGACY_MODE_I(legacy), .RESULT_VALID_O(vld), .TAKEN_O(tkn), .INVALID_FORM_O(inv),
        .NEXT_FETCH_O(nf), .LINK_WE_O(lwe), .LINK_DATA_O(ld), .TAKE_HINT_O(th),
        .USAGE_HINT_O(uh));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] mk(input logic [4:0] b);
        logic [31:0] r;
        r = xs();
        return {6'h13, b, r[4:0], 3'h0, r[6:5], 10'h210, r[7]};
    endfunction

    function automatic cbc_result_type model(input logic [31:0] w, a, c, r, input logic lg);
        cbc_insn_type i;
        logic [4:0] b;
        logic alw;
        i = w;
        b = i.branch_option_field;
        alw = b[4] & b[2];
        model = '0;
        model.valid = (i.primary_op == 6'h13) && (i.extended_op == 10'h210);
        model.invalid_form = !b[2] | (!lg & alw & (b[3] | b[1] | b[0]));
        model.taken = !model.invalid_form & (alw | (b[3] == r[~i.condition_bit_select]));
        model.link_write = !model.invalid_form & i.link_enable_bit;
        model.link_value = a + 32'h4;
        model.target = model.taken ? {c[31:2], 2'h0} : a + 32'h4;
        model.take_hint = cbc_hint_type'(alw ? 2'h0 : (lg ? {2{b[0]}} : b[1:0]));
        model.usage_hint = cbc_use_type'(i.branch_usage_hint);
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic step(input logic r, e, s, lg, input logic [31:0] w);
        @(posedge clk);
        #1;
        chk("valid", vld, ex.valid);
        if (ex.valid) begin
            chk("invalid", inv, ex.invalid_form);
            chk("taken", tkn, ex.taken);
            chk("fetch", nf, ex.target);
            chk("link_we", lwe, ex.link_write);
            if (ex.link_write) chk("link", ld, ex.link_value);
            chk("usage", uh, ex.usage_hint);
            if (hok && !ex.invalid_form) chk("hint", th, ex.take_hint);
        end else begin
            chk("idle_taken", tkn, 1'b0);
            chk("idle_invalid", inv, 1'b0);
            chk("idle_link_we", lwe, 1'b0);
        end
        rst = r;
        ce = e;
        issue = s & !r;
        legacy = lg;
        insn = w;
        addr = xs() & 32'hfffffffc;
        ctr = xs();
        cr = xs();
        if (r) ex = '0;
        else if (e) begin
            ex = model(insn, addr, ctr, cr, lg);
            ex.valid = ex.valid & s;
            // legacy branch-always hint is left open, so not compared
            hok = !(lg & w[25] & w[23]);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] r;
        {rst, ce, issue, legacy, hok} = 5'h19;
        {insn, addr, ctr, cr} = '0;
        ex = '0;
        for (int k = 0; k < 6; k++) step(1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
        for (int k = 0; k < 64; k++) step(1'b0, 1'b1, 1'b1, k[5], mk(k[4:0]));
        step(1'b0, 1'b1, 1'b1, 1'b0, mk(5'h14) ^ 32'h04000000);
        step(1'b0, 1'b1, 1'b1, 1'b0, mk(5'h14) ^ 32'h00000002);
        step(1'b0, 1'b0, 1'b1, 1'b0, mk(5'h0c));
        step(1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
        for (int k = 0; k < 2000; k++) begin
            r = xs();
            step(1'b0, r[0] | r[1], r[2] | r[3], r[4], r[5] ? xs() : mk(r[12:8]));
        end
        step(1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
